// ### rtl/bdb_pkg.sv
// package: constants and carriers for the object store descriptor builder
package bdb_pkg;

    // ------------------------------------------------------------
    // fixed header bytes
    // ------------------------------------------------------------
    localparam logic [7:0]  BOS_LEN        = 8'h05;
    localparam logic [7:0]  BOS_TYPE       = 8'h0F;
    localparam logic [7:0]  EXT_LEN        = 8'h07;
    localparam logic [7:0]  EXT_TYPE       = 8'h10;
    localparam logic [7:0]  EXT_CAP_TYPE   = 8'h02;

    // ------------------------------------------------------------
    // byte offsets in the returned stream; OFS_EXT_ATTR counts from OFS_EXT_BASE
    // ------------------------------------------------------------
    localparam logic [7:0]  OFS_BOS_LEN    = 8'h00;
    localparam logic [7:0]  OFS_BOS_TYPE   = 8'h01;
    localparam logic [7:0]  OFS_TOTAL_LO   = 8'h02;
    localparam logic [7:0]  OFS_TOTAL_HI   = 8'h03;
    localparam logic [7:0]  OFS_NUM_CAPS   = 8'h04;
    localparam logic [7:0]  OFS_EXT_BASE   = 8'h05;
    localparam logic [7:0]  OFS_EXT_ATTR   = 8'h03;
    localparam logic [7:0]  STREAM_BYTES   = 8'h0C;

    // ------------------------------------------------------------
    // values after reset (defaults until the image is loaded)
    // ------------------------------------------------------------
    localparam logic [15:0] RST_TOTAL_LEN  = 16'h0016;
    localparam logic [7:0]  RST_NUM_CAPS   = 8'h02;
    localparam logic [31:0] RST_ATTR       = 32'h0000_0006;

    // ------------------------------------------------------------
    // feature bitmap fields
    // ------------------------------------------------------------
    localparam int          ATTR_LPM_BIT   = 1;
    localparam int          ATTR_ALT_BIT   = 2;
    localparam int          ATTR_BASE_VLD  = 3;
    localparam int          ATTR_DEEP_VLD  = 4;
    localparam int          ATTR_BASE_LSB  = 8;
    localparam int          ATTR_DEEP_LSB  = 12;
    localparam logic [31:0] ATTR_KEEP_MASK = 32'h0000_FFFE;

    // stored image fields, as delivered by the configuration loader
    typedef struct packed {
        logic [7:0]  bos_len;
        logic [7:0]  bos_type;
        logic [15:0] total_len;
        logic [7:0]  num_caps;
        logic [7:0]  ext_len;
        logic [7:0]  ext_type;
        logic [7:0]  ext_cap_type;
        logic [31:0] ext_attr;
    } bdb_image_t;

    // descriptor read request from the control endpoint
    typedef struct packed {
        logic        start;
        logic [15:0] req_len;
    } bdb_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_DONE = 3'b100
    } bdb_state_t;

endpackage

// ### rtl/bdb_sync.sv
// module: two-stage synchroniser for a level from another domain
`timescale 1ns/100ps
module bdb_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,    // clock
    input  wire logic         rst_n_i,  // async reset, active low
    input  wire logic [W-1:0] d_i,      // asynchronous level
    output logic      [W-1:0] q_o       // synchronised level
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

// ### rtl/bdb_builder.sv
// module: object store descriptor builder and byte streamer
// ------------------------------------------------------------
// Summary of operation
// - header length 0x05, type 0x0F always forced
// - total length field taken from stored image
// - capability count taken from stored image
// - extension length, type, capability type forced
// - bitmap from image, bit 0 and bits 31:16 read zero
// - deep latency bits 15:12, valid bit 4
// - baseline latency bits 11:8, valid bit 3
// ------------------------------------------------------------
`timescale 1ns/100ps
module bdb_builder (
    input  wire logic                clk_i,         // 50 MHz device clock
    input  wire logic                rst_n_i,       // async reset, active low
    input  wire bdb_pkg::bdb_image_t image_i,       // stored image fields
    input  wire logic                load_i,        // image valid pulse
    input  wire logic                lpm_flag_i,    // link_power_mgmt_capable_flag
    input  wire bdb_pkg::bdb_req_t   req_i,         // descriptor read request
    input  wire logic                byte_ready_i,  // endpoint takes byte
    output logic                     byte_valid_o,  // byte available
    output logic [7:0]               byte_data_o,   // descriptor byte
    output logic                     byte_last_o,   // last byte of reply
    output logic                     busy_o,        // reply in progress
    output logic                     lpm_mismatch_o // image bit 1 disagrees with flag
);
    import bdb_pkg::*;

    // ------------------------------------------------------------
    // descriptor image held after load
    // ------------------------------------------------------------
    logic [15:0] total_ff,  nxt_total;
    logic [7:0]  caps_ff,   nxt_caps;
    logic [31:0] attr_ff,   nxt_attr;
    logic        mism_ff,   nxt_mism;
    logic        lpm_sync;

    // flag is a strap from the configuration side, so resync it
    bdb_sync #(.W(1)) u_lpm_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (lpm_flag_i),
        .q_o     (lpm_sync)
    );

    always_comb begin
        nxt_total = total_ff;
        nxt_caps  = caps_ff;
        nxt_attr  = attr_ff;
        if (load_i) begin
            nxt_total = image_i.total_len;
            nxt_caps  = image_i.num_caps;
            // latency fields and their valid bits pass in place
            nxt_attr  = image_i.ext_attr & ATTR_KEEP_MASK;
        end
        // follows a new image in the same edge that stores it
        nxt_mism = nxt_attr[ATTR_LPM_BIT] ^ lpm_sync;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            total_ff <= RST_TOTAL_LEN;
            caps_ff  <= RST_NUM_CAPS;
            attr_ff  <= RST_ATTR;
            // synchroniser leaves reset low, so only the default bit counts
            mism_ff  <= RST_ATTR[ATTR_LPM_BIT];
        end else begin
            total_ff <= nxt_total;
            caps_ff  <= nxt_caps;
            attr_ff  <= nxt_attr;
            mism_ff  <= nxt_mism;
        end
    end

    // only a status hint: the stream still returns the stored bit
    assign lpm_mismatch_o = mism_ff;

    // ------------------------------------------------------------
    // byte selection; header bytes from the image are never used
    // ------------------------------------------------------------
    function automatic logic [7:0] pick(input logic [7:0] idx);
        logic [7:0] e;
        e = idx - OFS_EXT_BASE;
        pick = 8'h00;
        case (idx)
            OFS_BOS_LEN:  pick = BOS_LEN;
            OFS_BOS_TYPE: pick = BOS_TYPE;
            OFS_TOTAL_LO: pick = total_ff[7:0];
            OFS_TOTAL_HI: pick = total_ff[15:8];
            OFS_NUM_CAPS: pick = caps_ff;
            default: begin
                case (e)
                    8'h00:   pick = EXT_LEN;
                    8'h01:   pick = EXT_TYPE;
                    8'h02:   pick = EXT_CAP_TYPE;
                    8'h03:   pick = attr_ff[7:0];
                    8'h04:   pick = attr_ff[15:8];
                    8'h05:   pick = attr_ff[23:16];
                    8'h06:   pick = attr_ff[31:24];
                    default: pick = 8'h00;
                endcase
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // reply streamer
    // ------------------------------------------------------------
    bdb_state_t  state_ff, nxt_state;
    logic [7:0]  idx_ff,   nxt_idx;
    logic [7:0]  cnt_ff,   nxt_cnt;
    logic [7:0]  data_ff,  nxt_data;
    logic        last_ff,  nxt_last;
    logic [7:0]  limit;

    // reply length is the smaller of request and built stream
    always_comb begin
        limit = STREAM_BYTES;
        if (req_i.req_len < {8'h00, STREAM_BYTES}) begin
            limit = req_i.req_len[7:0];
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_idx   = idx_ff;
        nxt_cnt   = cnt_ff;
        nxt_data  = data_ff;
        nxt_last  = last_ff;
        case (state_ff)
            ST_IDLE: begin
                if (req_i.start && limit != 8'h00) begin
                    nxt_state = ST_SEND;
                    nxt_idx   = 8'h01;
                    nxt_cnt   = limit;
                    nxt_data  = pick(8'h00);
                    nxt_last  = (limit == 8'h01);
                end
            end
            ST_SEND: begin
                if (byte_ready_i) begin
                    if (last_ff) begin
                        nxt_state = ST_DONE;
                        nxt_last  = 1'b0;
                    end else begin
                        nxt_data = pick(idx_ff);
                        nxt_idx  = idx_ff + 8'h01;
                        nxt_last = (idx_ff + 8'h01 == cnt_ff);
                    end
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            idx_ff   <= 8'h00;
            cnt_ff   <= 8'h00;
            data_ff  <= 8'h00;
            last_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idx_ff   <= nxt_idx;
            cnt_ff   <= nxt_cnt;
            data_ff  <= nxt_data;
            last_ff  <= nxt_last;
        end
    end

    assign byte_valid_o = (state_ff == ST_SEND);
    assign byte_data_o  = data_ff;
    assign byte_last_o  = last_ff & (state_ff == ST_SEND);
    assign busy_o       = (state_ff != ST_IDLE);
endmodule

// ### dv/bdb_chk.sv
// checker: handshake and header assertions on the builder ports
`timescale 1ns/100ps
module bdb_chk (
    input wire logic              clk_i,         // clock
    input wire logic              rst_n_i,       // reset, active low
    input wire logic              load_i,        // image load
    input wire logic              lpm_flag_i,    // capable flag
    input wire bdb_pkg::bdb_req_t req_i,         // request
    input wire logic              byte_ready_i,  // host takes byte
    input wire logic              byte_valid_o,  // byte offered
    input wire logic [7:0]        byte_data_o,   // byte
    input wire logic              byte_last_o,   // last byte
    input wire logic              busy_o,        // reply running
    input wire logic              lpm_mismatch_o // flag disagreement
);
    import bdb_pkg::*;
    // ----------------------------------------
    // reply and mismatch flag properties
    // ----------------------------------------
    wire go = req_i.start && !busy_o;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    hdr_first_a: assert property (go && req_i.req_len != 16'h0000
        |=> byte_valid_o && byte_data_o == 8'h05) else $error("bad first byte");
    hdr_second_a: assert property ($past(go) && byte_valid_o && byte_ready_i
        && !byte_last_o |=> byte_data_o == 8'h0F) else $error("bad second byte");
    zero_len_a: assert property (go && req_i.req_len == 16'h0000
        |=> !busy_o) else $error("reply to zero length");
    one_byte_a: assert property (go && req_i.req_len == 16'h0001
        |=> byte_last_o) else $error("one byte not last");
    byte_hold_a: assert property (byte_valid_o && !byte_ready_i
        |=> byte_valid_o && $stable(byte_data_o)) else $error("byte dropped");
    reply_end_a: assert property (byte_valid_o && byte_last_o && byte_ready_i
        |=> !byte_valid_o && busy_o ##1 !busy_o) else $error("bad reply end");
    valid_busy_a: assert property (byte_valid_o |-> busy_o)
        else $error("valid while idle");
    flag_track_a: assert property ($changed(lpm_flag_i) && !load_i
        |-> ##[1:3] $changed(lpm_mismatch_o)) else $error("mismatch stuck");
endmodule
bind bdb_builder bdb_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .load_i(load_i),
    .lpm_flag_i(lpm_flag_i), .req_i(req_i), .byte_ready_i(byte_ready_i),
    .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o), .byte_last_o(byte_last_o),
    .busy_o(busy_o), .lpm_mismatch_o(lpm_mismatch_o));

// ### dv/bdb_host.sv
// partner: host end of the byte handshake, optionally stalling
`timescale 1ns/100ps
module bdb_host (
    input  wire logic clk_i,   // clock
    input  wire logic rst_n_i, // reset, active low
    input  wire logic stall_i, // take only every other cycle
    output logic      ready_o  // host takes byte
);
    logic ready_ff;
    logic nxt_ready;
    // stalls ignore valid, as a busy host would
    always_comb nxt_ready = stall_i ? !ready_ff : 1'b1;
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            ready_ff <= 1'b0;
        else
            ready_ff <= nxt_ready;
    assign ready_o = ready_ff;
endmodule

// ### dv/test_bdb_builder.sv
// testbench: descriptor reads and image loads against the builder
`timescale 1ns/100ps
module test_bdb_builder;
    import bdb_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        load = 1'b0;
    logic        flag = 1'b0;
    logic        stall = 1'b0;
    logic        rdy, vld, last, busy, mism;
    logic [7:0]  dat;
    logic [15:0] e_tot = 16'h0016;
    logic [7:0]  e_caps = 8'h02;
    logic [31:0] e_attr = 32'h0000_0006;
    bdb_image_t  img = '1;
    bdb_req_t    req = '0;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    bdb_builder DUT (.clk_i, .rst_n_i, .image_i(img), .load_i(load), .lpm_flag_i(flag),
        .req_i(req), .byte_ready_i(rdy), .byte_valid_o(vld), .byte_data_o(dat),
        .byte_last_o(last), .busy_o(busy), .lpm_mismatch_o(mism));
    bdb_host u_host (.clk_i, .rst_n_i, .stall_i(stall), .ready_o(rdy));
    initial forever #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            err_count++;
        end
    endtask
    function automatic logic [7:0] eb(int k);
        logic [95:0] s;
        s = {e_attr & 32'h0000_FFFE, 8'h02, 8'h10, 8'h07, e_caps, e_tot, 8'h0F, 8'h05};
        return s[8*k +: 8];
    endfunction
    // header bytes of the stored image are junk on purpose
    task automatic ld(input logic [15:0] t, input logic [7:0] c, input logic [31:0] a);
        img = {8'hAA, 8'h55, t, c, 8'hEE, 8'h77, 8'h99, a};
        load = 1'b1;
        @(negedge clk_i);
        load = 1'b0;
        e_tot = t;
        e_caps = c;
        e_attr = a;
    endtask
    // sampled at the falling edge, so ready and valid are settled
    task automatic rd(input logic [15:0] len);
        int n;
        int k;
        n = (len > 16'h000C) ? 12 : int'(len);
        k = 0;
        while (busy) @(negedge clk_i);
        req = '{1'b1, len};
        @(negedge clk_i);
        req.start = 1'b0;
        while (k < n) begin
            if (vld && rdy) begin
                chk("byte", eb(k), dat);
                chk("last", {7'h00, k == n - 1}, {7'h00, last});
                k++;
            end
            @(negedge clk_i);
        end
        if (n == 0) chk("busy", 8'h00, {7'h00, busy});
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("mismatch", 8'h01, {7'h00, mism});
        rd(16'h0040);
        stall = 1'b1;
        ld(16'h1234, 8'h05, 32'h5A5A_A51F);
        rd(16'h000C);
        rd(16'h0001);
        stall = 1'b0;
        rd(16'h0007);
        rd(16'h0000);
        flag = 1'b1;
        repeat (4) @(negedge clk_i);
        chk("mismatch", 8'h00, {7'h00, mism});
        ld(16'h0016, 8'h02, 32'h0000_0018);
        repeat (3) @(negedge clk_i);
        chk("mismatch", 8'h01, {7'h00, mism});
        rd(16'h000C);
        report_and_stop();
    end
endmodule
